// ### logic/line_overhead_error_counters.sv
// Purpose: Line overhead error counters, transmit insertion controls and path alarm status
// Assumes: Receive error inputs synchronous to clk_sys_i, one report per frame
// Notes: Register port is 8 bits wide, read data one cycle after the read strobe
//
// Operation
// - About 1 us after a write to any counter holding register or to offset 0x00, the parity count is copied into its holding registers.
// - In that same cycle the internal parity counter restarts from the parity errors of that cycle, so none are lost.
// - Reading the three parity holding registers returns the errors of the last interval, valid unless the counter overflowed.
// - On the same trigger and delay the far-end block error count is copied into its holding registers.
// - When the far-end holding registers load, the internal far-end counter restarts from the far-end errors of that cycle.
// - Reading the three far-end holding registers returns the far-end errors of the last interval, valid unless overflowed.
// - The transmitted K2 bits 6 to 8 are 000 with the defect insert bit clear and 110 with it set.
// - While the parity corrupt bit is set every outgoing B2 byte is inverted, otherwise B2 passes unchanged.
// - The parity counter adds one per errored frame or one per errored bit, as the per-bit setting selects.
// - Path alarm status shows pointer loss, path alarm indication and path remote defect as read-only live flags.

`timescale 1ns/100ps

module line_overhead_error_counters
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Register port
   input wire line_oh_pkg::reg_req_s reg_req_i,
   output logic [line_oh_pkg::DATA_W-1:0] reg_rdata_o,
   // Receive line overhead error reports
   input wire logic b2_err_valid_i,
   input wire logic [line_oh_pkg::B2_BITS-1:0] b2_err_bits_i,
   input wire logic z2_err_valid_i,
   input wire logic [line_oh_pkg::INC_W-1:0] z2_err_count_i,
   // Receive path alarms
   input wire line_oh_pkg::path_alarm_s path_alarm_i,
   // Transmit overhead
   input wire line_oh_pkg::tx_oh_s tx_oh_i,
   output line_oh_pkg::tx_oh_s tx_oh_o,
   // Interrupt
   output logic irq_o
);
   import line_oh_pkg::*;

   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      snap_state_e snap;
      logic [DELAY_W-1:0] delay;
      logic [CNT_W-1:0] parity_hold;
      logic [CNT_W-1:0] far_hold;
      logic per_bit_parity_counting;
      logic line_remote_defect_insert;
      logic line_parity_corrupt;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [DATA_W-1:0] rdata;
   } top_state_s;

   localparam logic [DELAY_W-1:0] DELAY_LOAD = DELAY_W'(SNAP_DELAY_CYC - 1);

   top_state_s state_ff;
   top_state_s nxt_state;

   logic [INC_W-1:0] parity_inc;
   logic [INC_W-1:0] far_inc;
   logic [INC_W-1:0] bit_errs;
   logic snap_pulse;
   logic trigger_wr;
   logic [CNT_W-1:0] parity_count;
   logic [CNT_W-1:0] far_count;
   logic parity_sat;
   logic far_sat;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_w1c;

   // ********************************************
   // Parity error weighting
   // ********************************************
   function automatic logic [INC_W-1:0] count_ones(input logic [B2_BITS-1:0] v);
      logic [INC_W-1:0] n;
      n = '0;
      for (int i = 0; i < B2_BITS; i++)
      begin
         n = n + INC_W'(v[i]);
      end
      return n;
   endfunction

   always_comb
   begin
      bit_errs = count_ones(b2_err_bits_i);
      parity_inc = '0;
      if (b2_err_valid_i && (bit_errs != '0))
      begin
         // Per-frame mode counts a frame once however many bits failed
         parity_inc = state_ff.per_bit_parity_counting ? bit_errs : INC_W'(1);
      end
      far_inc = z2_err_valid_i ? z2_err_count_i : '0;
   end

   // ********************************************
   // Accumulators
   // ********************************************
   err_accum
   #(
      .WIDTH(CNT_W),
      .INC_W(INC_W)
   )
   u_parity_accum
   (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(parity_inc),
      .clear_i(snap_pulse),
      .count_o(parity_count),
      .sat_o(parity_sat)
   );

   err_accum
   #(
      .WIDTH(CNT_W),
      .INC_W(INC_W)
   )
   u_far_accum
   (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(far_inc),
      .clear_i(snap_pulse),
      .count_o(far_count),
      .sat_o(far_sat)
   );

   // ********************************************
   // Snapshot trigger decode
   // ********************************************
   always_comb
   begin
      trigger_wr = 1'b0;
      if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            ADDR_TRIGGER,
            ADDR_PARITY_LOW,
            ADDR_PARITY_MID,
            ADDR_PARITY_HIGH,
            ADDR_FAR_LOW,
            ADDR_FAR_MID,
            ADDR_FAR_HIGH: trigger_wr = 1'b1;
            default: trigger_wr = 1'b0;
         endcase
      end
   end

   // Snapshot fires when the delay runs out; a trigger on that very edge postpones it,
   // so the counters are never cleared without their totals being captured
   assign snap_pulse = (state_ff.snap == SNAP_WAIT) && (state_ff.delay == '0) && !trigger_wr;

   // ********************************************
   // Interrupt sources
   // ********************************************
   always_comb
   begin
      irq_events = '0;
      irq_events[IRQ_PARITY_POS] = (parity_inc != '0);
      irq_events[IRQ_FAR_POS] = (far_inc != '0);
      irq_events[IRQ_SNAP_POS] = snap_pulse;
      // Overflowed interval flagged when it is captured, so software can discard it
      irq_events[IRQ_OVF_POS] = snap_pulse && (parity_sat || far_sat);
      irq_w1c = '0;
      if (reg_req_i.wr && (reg_req_i.addr == ADDR_IRQ_STATUS))
      begin
         irq_w1c = reg_req_i.wdata[IRQ_W-1:0];
      end
   end

   // ********************************************
   // Next state
   // ********************************************
   always_comb
   begin
      nxt_state = state_ff;

      // Snapshot sequencer; a new trigger while waiting restarts the delay
      case (state_ff.snap)
         SNAP_IDLE:
         begin
            if (trigger_wr)
            begin
               nxt_state.snap = SNAP_WAIT;
               nxt_state.delay = DELAY_LOAD;
            end
         end
         SNAP_WAIT:
         begin
            if (trigger_wr)
            begin
               nxt_state.delay = DELAY_LOAD;
            end
            else if (state_ff.delay == '0)
            begin
               nxt_state.snap = SNAP_IDLE;
            end
            else
            begin
               nxt_state.delay = state_ff.delay - DELAY_W'(1);
            end
         end
         default:
         begin
            nxt_state.snap = SNAP_IDLE;
            nxt_state.delay = '0;
         end
      endcase

      if (snap_pulse && !trigger_wr)
      begin
         nxt_state.parity_hold = parity_count;
         nxt_state.far_hold = far_count;
      end

      // Control registers
      if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            ADDR_RX_LINE_CTRL:
               nxt_state.per_bit_parity_counting = reg_req_i.wdata[PER_BIT_POS];
            ADDR_TX_CTRL:
               nxt_state.line_remote_defect_insert = reg_req_i.wdata[REMOTE_DEFECT_POS];
            ADDR_TX_ERR_INSERT:
               nxt_state.line_parity_corrupt = reg_req_i.wdata[PARITY_CORRUPT_POS];
            ADDR_IRQ_MASK:
               nxt_state.irq_mask = reg_req_i.wdata[IRQ_W-1:0];
            default:
               nxt_state.irq_mask = state_ff.irq_mask;
         endcase
      end

      // Set beats a simultaneous write-one clear
      nxt_state.irq_status = (state_ff.irq_status & ~irq_w1c) | irq_events;

      // Read data, valid the cycle after the strobe only
      nxt_state.rdata = '0;
      if (reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            ADDR_RX_LINE_CTRL:
               nxt_state.rdata[PER_BIT_POS] = state_ff.per_bit_parity_counting;
            ADDR_PARITY_LOW:
               nxt_state.rdata = state_ff.parity_hold[7:0];
            ADDR_PARITY_MID:
               nxt_state.rdata = state_ff.parity_hold[15:8];
            ADDR_PARITY_HIGH:
               nxt_state.rdata[HIGH_BITS-1:0] = state_ff.parity_hold[19:16];
            ADDR_FAR_LOW:
               nxt_state.rdata = state_ff.far_hold[7:0];
            ADDR_FAR_MID:
               nxt_state.rdata = state_ff.far_hold[15:8];
            ADDR_FAR_HIGH:
               nxt_state.rdata[HIGH_BITS-1:0] = state_ff.far_hold[19:16];
            ADDR_TX_CTRL:
               nxt_state.rdata[REMOTE_DEFECT_POS] = state_ff.line_remote_defect_insert;
            ADDR_TX_ERR_INSERT:
               nxt_state.rdata[PARITY_CORRUPT_POS] = state_ff.line_parity_corrupt;
            ADDR_PATH_ALARM:
            begin
               nxt_state.rdata[POINTER_LOSS_POS] = path_alarm_i.pointer_loss_alarm;
               nxt_state.rdata[PATH_AIS_POS] = path_alarm_i.path_alarm_indication;
               nxt_state.rdata[PATH_REMOTE_POS] = path_alarm_i.path_remote_defect_alarm;
            end
            ADDR_IRQ_STATUS:
               nxt_state.rdata[IRQ_W-1:0] = state_ff.irq_status;
            ADDR_IRQ_MASK:
               nxt_state.rdata[IRQ_W-1:0] = state_ff.irq_mask;
            default:
               nxt_state.rdata = '0;
         endcase
      end
   end

   // ********************************************
   // Registers
   // ********************************************
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff.snap <= SNAP_IDLE;
         state_ff.delay <= '0;
         state_ff.parity_hold <= CNT_RESET;
         state_ff.far_hold <= CNT_RESET;
         state_ff.per_bit_parity_counting <= CTRL_RESET[PER_BIT_POS];
         state_ff.line_remote_defect_insert <= CTRL_RESET[REMOTE_DEFECT_POS];
         state_ff.line_parity_corrupt <= CTRL_RESET[PARITY_CORRUPT_POS];
         state_ff.irq_status <= IRQ_RESET;
         state_ff.irq_mask <= IRQ_RESET;
         state_ff.rdata <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ********************************************
   // Transmit insertion
   // ********************************************
   tx_oh_insert u_tx_insert
   (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .tx_oh_i(tx_oh_i),
      .line_remote_defect_insert_i(state_ff.line_remote_defect_insert),
      .line_parity_corrupt_i(state_ff.line_parity_corrupt),
      .tx_oh_o(tx_oh_o)
   );

   assign reg_rdata_o = state_ff.rdata;
   assign irq_o = |(state_ff.irq_status & state_ff.irq_mask);

endmodule

// ### pkg/line_oh_pkg.sv
// Purpose: Shared constants and types for the line overhead error counter slice
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: Register offsets are byte addresses on the local register port

package line_oh_pkg;

   // ********************************************
   // Widths
   // ********************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 20;
   localparam int INC_W = 5;
   localparam int B2_BITS = 24;

   // ********************************************
   // Register offsets
   // ********************************************
   localparam logic [7:0] ADDR_TRIGGER = 8'h00;
   localparam logic [7:0] ADDR_RX_LINE_CTRL = 8'h18;
   localparam logic [7:0] ADDR_PARITY_LOW = 8'h1a;
   localparam logic [7:0] ADDR_PARITY_MID = 8'h1b;
   localparam logic [7:0] ADDR_PARITY_HIGH = 8'h1c;
   localparam logic [7:0] ADDR_FAR_LOW = 8'h1d;
   localparam logic [7:0] ADDR_FAR_MID = 8'h1e;
   localparam logic [7:0] ADDR_FAR_HIGH = 8'h1f;
   localparam logic [7:0] ADDR_TX_CTRL = 8'h20;
   localparam logic [7:0] ADDR_TX_ERR_INSERT = 8'h21;
   localparam logic [7:0] ADDR_PATH_ALARM = 8'h30;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h41;

   // ********************************************
   // Field positions
   // ********************************************
   localparam int PER_BIT_POS = 7;
   localparam int REMOTE_DEFECT_POS = 0;
   localparam int PARITY_CORRUPT_POS = 0;
   localparam int POINTER_LOSS_POS = 5;
   localparam int PATH_AIS_POS = 3;
   localparam int PATH_REMOTE_POS = 2;
   localparam int HIGH_BITS = 4;
   localparam int IRQ_W = 4;
   localparam int IRQ_PARITY_POS = 0;
   localparam int IRQ_FAR_POS = 1;
   localparam int IRQ_SNAP_POS = 2;
   localparam int IRQ_OVF_POS = 3;

   // ********************************************
   // Reset values and codes
   // ********************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   localparam logic [19:0] CNT_RESET = 20'h00000;
   localparam logic [2:0] K2_DEFECT_CODE = 3'b110;
   localparam logic [2:0] K2_NORMAL_CODE = 3'b000;

   // ********************************************
   // Timing
   // ********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SNAP_DELAY_NS = 1000;
   localparam int SNAP_DELAY_CYC = SNAP_DELAY_NS / CLK_PERIOD_NS;
   localparam int DELAY_W = 8;

   // ********************************************
   // Types
   // ********************************************
   typedef enum logic [1:0] {
      SNAP_IDLE = 2'b01,
      SNAP_WAIT = 2'b10
   } snap_state_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] k2;
      logic [7:0] b2;
   } tx_oh_s;

   typedef struct packed {
      logic pointer_loss_alarm;
      logic path_alarm_indication;
      logic path_remote_defect_alarm;
   } path_alarm_s;

endpackage

// ### logic/err_accum.sv
// Purpose: Saturating error accumulator with snapshot-and-restart
// Assumes: Increment arrives once per cycle, clear is a one-cycle pulse
// Notes: On clear the current cycle's increment starts the new interval

`timescale 1ns/100ps

module err_accum
#(
   parameter int WIDTH = 20,
   parameter int INC_W = 5
)
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [INC_W-1:0] inc_i,
   input wire logic clear_i,
   output logic [WIDTH-1:0] count_o,
   output logic sat_o
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } acc_state_s;

   acc_state_s state_ff;
   acc_state_s nxt_state;
   logic [WIDTH:0] sum;
   logic [WIDTH-1:0] inc_ext;

   assign inc_ext = WIDTH'(inc_i);

   always_comb
   begin
      nxt_state = state_ff;
      sum = {1'b0, state_ff.count} + {1'b0, inc_ext};
      if (clear_i)
      begin
         // Errors in the snapshot cycle belong to the next interval, none lost
         nxt_state.count = inc_ext;
      end
      else if (sum[WIDTH])
      begin
         nxt_state.count = '1;
      end
      else
      begin
         nxt_state.count = sum[WIDTH-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign count_o = state_ff.count;
   assign sat_o = &state_ff.count;

endmodule

// ### logic/tx_oh_insert.sv
// Purpose: Transmit line overhead insertion of remote defect code and parity corruption
// Assumes: K2 and B2 bytes arrive together with a valid strobe
// Notes: One cycle of latency, output registered

`timescale 1ns/100ps

module tx_oh_insert
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire line_oh_pkg::tx_oh_s tx_oh_i,
   input wire logic line_remote_defect_insert_i,
   input wire logic line_parity_corrupt_i,
   output line_oh_pkg::tx_oh_s tx_oh_o
);
   import line_oh_pkg::*;

   typedef struct packed {
      tx_oh_s out;
   } ins_state_s;

   ins_state_s state_ff;
   ins_state_s nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.out.valid = tx_oh_i.valid;
      if (tx_oh_i.valid)
      begin
         // SONET bits 6..8 are the three least significant bits
         nxt_state.out.k2 = {tx_oh_i.k2[7:3],
            line_remote_defect_insert_i ? K2_DEFECT_CODE : K2_NORMAL_CODE};
         nxt_state.out.b2 = line_parity_corrupt_i ? ~tx_oh_i.b2 : tx_oh_i.b2;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign tx_oh_o = state_ff.out;

endmodule

// ### verif/line_oh_checker.sv
// Purpose: Port-level assertions for the line overhead error counter slice
// Assumes: Single clock domain, register writes mirrored here for control bits
// Notes: Bound to the top module at the foot of this file

`timescale 1ns/100ps

module line_oh_checker
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire line_oh_pkg::reg_req_s reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire line_oh_pkg::path_alarm_s path_alarm_i,
   input wire line_oh_pkg::tx_oh_s tx_oh_i,
   input wire line_oh_pkg::tx_oh_s tx_oh_o,
   input wire logic irq_o
);
   import line_oh_pkg::*;

   // ***********************************
   // Mirror of the control bits
   // ***********************************
   logic rdi_ff;
   logic corrupt_ff;
   logic [3:0] mask_ff;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rdi_ff <= 1'b0;
         corrupt_ff <= 1'b0;
         mask_ff <= 4'h0;
      end
      else if (reg_req_i.wr)
      begin
         if (reg_req_i.addr == ADDR_TX_CTRL)
            rdi_ff <= reg_req_i.wdata[0];
         if (reg_req_i.addr == ADDR_TX_ERR_INSERT)
            corrupt_ff <= reg_req_i.wdata[0];
         if (reg_req_i.addr == ADDR_IRQ_MASK)
            mask_ff <= reg_req_i.wdata[3:0];
      end
   end

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence rd_at(logic [7:0] a);
      reg_req_i.rd && reg_req_i.addr == a;
   endsequence

   AST_RDATA_IDLE: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_K2_CODE: assert property (tx_oh_i.valid |=> tx_oh_o.k2 ==
      {$past(tx_oh_i.k2[7:3]), ($past(rdi_ff) ? 3'h6 : 3'h0)})
      else $error("transmitted K2 defect code wrong");
   AST_B2_INVERT: assert property (tx_oh_i.valid |=> tx_oh_o.b2 ==
      ($past(corrupt_ff) ? ~$past(tx_oh_i.b2) : $past(tx_oh_i.b2)))
      else $error("transmitted B2 byte wrong");
   AST_TX_HOLD: assert property (!tx_oh_i.valid |=> $stable({tx_oh_o.k2, tx_oh_o.b2}))
      else $error("transmit bytes changed without input");
   AST_ALARM_LIVE: assert property (rd_at(ADDR_PATH_ALARM) |=> reg_rdata_o ==
      {2'h0, $past(path_alarm_i.pointer_loss_alarm), 1'b0,
       $past(path_alarm_i.path_alarm_indication),
       $past(path_alarm_i.path_remote_defect_alarm), 2'h0})
      else $error("path alarm status read wrong");
   AST_CTRL_READBACK: assert property (rd_at(ADDR_TX_CTRL) |=>
      reg_rdata_o == {7'h00, $past(rdi_ff)})
      else $error("defect insert control read back wrong");
   AST_INSERT_READBACK: assert property (rd_at(ADDR_TX_ERR_INSERT) |=>
      reg_rdata_o == {7'h00, $past(corrupt_ff)})
      else $error("parity corrupt control read back wrong");
   AST_HIGH_NIBBLE: assert property (reg_req_i.rd && (reg_req_i.addr == ADDR_PARITY_HIGH ||
      reg_req_i.addr == ADDR_FAR_HIGH) |=> reg_rdata_o[7:4] == 4'h0)
      else $error("unused bits of a high count byte not zero");
   AST_IRQ_MASKED: assert property (irq_o |-> mask_ff != 4'h0)
      else $error("interrupt raised with every source masked");

endmodule

bind line_overhead_error_counters line_oh_checker u_chk (.clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
   .path_alarm_i(path_alarm_i), .tx_oh_i(tx_oh_i), .tx_oh_o(tx_oh_o), .irq_o(irq_o));

// ### verif/testbench.sv
// Purpose: Self-checking bench for the line overhead error counter slice
// Assumes: Register reads answer in the cycle after the read strobe
// Notes: Saturation run is long on purpose, about 44k cycles

`timescale 1ns/100ps

module testbench;
   import line_oh_pkg::*;

   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   reg_req_s reg_req = '0;
   logic [7:0] reg_rdata;
   logic b2_valid = 1'b0;
   logic [23:0] b2_bits = 24'h000000;
   logic z2_valid = 1'b0;
   logic [4:0] z2_count = 5'h00;
   path_alarm_s alarm = '0;
   tx_oh_s tx_in = '0;
   tx_oh_s tx_out;
   logic irq;
   int mismatches = 0;
   int samples_checked = 0;
   logic [7:0] rd_val;
   logic [23:0] cnt_val;

   always #5 clk_sys_i = ~clk_sys_i;

   line_overhead_error_counters dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .reg_req_i(reg_req), .reg_rdata_o(reg_rdata), .b2_err_valid_i(b2_valid),
      .b2_err_bits_i(b2_bits), .z2_err_valid_i(z2_valid), .z2_err_count_i(z2_count),
      .path_alarm_i(alarm), .tx_oh_i(tx_in), .tx_oh_o(tx_out), .irq_o(irq));

   // ***********************************
   // Access tasks
   // ***********************************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Each task leaves one idle edge so no strobe is set and cleared in one step
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_req.wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic reg_rd(input logic [7:0] a);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_req.rd <= 1'b0;
      @(negedge clk_sys_i);
      rd_val = reg_rdata;
      @(posedge clk_sys_i);
   endtask

   task automatic rd_count(input logic [7:0] base);
      reg_rd(base);
      cnt_val[7:0] = rd_val;
      reg_rd(base + 8'h01);
      cnt_val[15:8] = rd_val;
      reg_rd(base + 8'h02);
      cnt_val[23:16] = rd_val;
   endtask

   task automatic frames(input int n, input logic [23:0] bits, input logic [4:0] z);
      b2_valid <= 1'b1;
      b2_bits <= bits;
      z2_valid <= 1'b1;
      z2_count <= z;
      repeat (n) @(posedge clk_sys_i);
      b2_valid <= 1'b0;
      z2_valid <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic snapshot(input logic [7:0] a);
      reg_wr(a, 8'h00);
      repeat (100) @(posedge clk_sys_i);
   endtask

   task automatic tx_send(input logic [7:0] k2, b2, ek2, eb2);
      tx_in <= '{1'b1, k2, b2};
      @(posedge clk_sys_i);
      tx_in.valid <= 1'b0;
      @(negedge clk_sys_i);
      check("tx k2", {16'h0000, tx_out.k2}, {16'h0000, ek2});
      check("tx b2", {16'h0000, tx_out.b2}, {16'h0000, eb2});
      check("tx valid", {23'h000000, tx_out.valid}, 24'h000001);
      @(posedge clk_sys_i);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ***********************************
   // Tests
   // ***********************************
   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int i = 0; i < 8; i++)
      begin
         reg_rd(ADDR_PARITY_LOW + i[7:0]);
         check("reset value", {16'h0000, rd_val}, 24'h000000);
      end
      $display("test reset values done");
      frames(4, 24'h000013, 5'h05);
      frames(2, 24'h000000, 5'h00);
      reg_wr(ADDR_TRIGGER, 8'h00);
      // Read lands one edge before the snapshot, so the old value must show
      repeat (97) @(posedge clk_sys_i);
      reg_rd(ADDR_PARITY_LOW);
      check("early parity", {16'h0000, rd_val}, 24'h000000);
      rd_count(ADDR_PARITY_LOW);
      check("frame parity", cnt_val, 24'h000004);
      rd_count(ADDR_FAR_LOW);
      check("frame far end", cnt_val, 24'h000014);
      $display("test per-frame counting done");
      reg_wr(ADDR_RX_LINE_CTRL, 8'h80);
      reg_rd(ADDR_RX_LINE_CTRL);
      check("per-bit setting", {16'h0000, rd_val}, 24'h000080);
      frames(3, 24'h800301, 5'h01);
      snapshot(ADDR_FAR_LOW);
      rd_count(ADDR_PARITY_LOW);
      check("bit parity", cnt_val, 24'h00000c);
      rd_count(ADDR_FAR_LOW);
      check("bit far end", cnt_val, 24'h000003);
      snapshot(ADDR_PARITY_MID);
      rd_count(ADDR_PARITY_LOW);
      check("cleared parity", cnt_val, 24'h000000);
      rd_count(ADDR_FAR_LOW);
      check("cleared far end", cnt_val, 24'h000000);
      // A second trigger inside the wait restarts the delay
      frames(2, 24'h000001, 5'h02);
      reg_wr(ADDR_PARITY_HIGH, 8'h00);
      repeat (48) @(posedge clk_sys_i);
      reg_wr(ADDR_FAR_MID, 8'h00);
      repeat (49) @(posedge clk_sys_i);
      reg_rd(ADDR_PARITY_LOW);
      check("restart early", {16'h0000, rd_val}, 24'h000000);
      repeat (48) @(posedge clk_sys_i);
      rd_count(ADDR_PARITY_LOW);
      check("restart parity", cnt_val, 24'h000002);
      rd_count(ADDR_FAR_LOW);
      check("restart far end", cnt_val, 24'h000004);
      $display("test per-bit counting done");
      frames(43700, 24'hffffff, 5'h1f);
      snapshot(ADDR_FAR_HIGH);
      rd_count(ADDR_PARITY_LOW);
      check("sat parity", cnt_val, 24'h0fffff);
      rd_count(ADDR_FAR_LOW);
      check("sat far end", cnt_val, 24'h0fffff);
      reg_rd(ADDR_IRQ_STATUS);
      check("irq status", {16'h0000, rd_val}, 24'h00000f);
      check("irq masked", {23'h000000, irq}, 24'h000000);
      reg_wr(ADDR_IRQ_MASK, 8'h02);
      reg_rd(ADDR_IRQ_MASK);
      check("irq mask", {16'h0000, rd_val}, 24'h000002);
      check("irq raised", {23'h000000, irq}, 24'h000001);
      reg_wr(ADDR_IRQ_STATUS, 8'h02);
      reg_rd(ADDR_IRQ_STATUS);
      check("irq cleared bit", {16'h0000, rd_val}, 24'h00000d);
      check("irq dropped", {23'h000000, irq}, 24'h000000);
      reg_wr(ADDR_IRQ_STATUS, 8'h0f);
      reg_rd(ADDR_IRQ_STATUS);
      check("irq all clear", {16'h0000, rd_val}, 24'h000000);
      $display("test saturation and interrupt done");
      reg_wr(ADDR_TX_CTRL, 8'h01);
      reg_wr(ADDR_TX_ERR_INSERT, 8'h01);
      reg_rd(ADDR_TX_CTRL);
      check("defect insert bit", {16'h0000, rd_val}, 24'h000001);
      tx_send(8'hff, 8'h5a, 8'hfe, 8'ha5);
      reg_wr(ADDR_TX_CTRL, 8'h00);
      reg_wr(ADDR_TX_ERR_INSERT, 8'h00);
      tx_send(8'hff, 8'h5a, 8'hf8, 8'h5a);
      reg_wr(ADDR_TX_CTRL, 8'h01);
      tx_send(8'h00, 8'h3c, 8'h06, 8'h3c);
      $display("test transmit insertion done");
      alarm <= '{1'b1, 1'b0, 1'b1};
      reg_rd(ADDR_PATH_ALARM);
      check("alarm a", {16'h0000, rd_val}, 24'h000024);
      alarm <= '{1'b0, 1'b1, 1'b0};
      reg_wr(ADDR_PATH_ALARM, 8'hff);
      reg_rd(ADDR_PATH_ALARM);
      check("alarm b", {16'h0000, rd_val}, 24'h000008);
      reg_rd(8'h55);
      check("unmapped", {16'h0000, rd_val}, 24'h000000);
      $display("test path alarm done");
      print_verdict();
   end

   // A hang costs one mismatch and ends the run the normal way
   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      mismatches++;
      print_verdict();
   end

endmodule
